//--- clock_gate.sv
// Gate for a sampled clock level: run and drive change only in the low phase.
// Assumes clock_level is already in the clock domain.
`timescale 1ns/100ps
`default_nettype none
module clock_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Source and controls
  input wire logic clock_level,
  input wire logic run,
  input wire logic drive,
  // Gated result
  output logic gated,
  output logic drive_out
);

  logic run_held;

  // Controls follow only while the source is low, so no high phase is cut
  always_ff @(posedge clock) begin
    if (srst) begin
      run_held <= 1'b0;
      drive_out <= 1'b0;
    end else if (!clock_level) begin
      run_held <= run;
      drive_out <= drive;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gated <= 1'b0;
    end else begin
      gated <= clock_level & run_held;
    end
  end

endmodule : clock_gate
`default_nettype wire

//--- clock_gate_fix_note_placeholder.sv
`timescale 1ns/100ps

//--- level_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : level_sync
`default_nettype wire

//--- otp_image_model.sv
// Far-side model: OTP image with registered read, plus reference and PLL clock levels.
// Assumes the decode block reads addresses 0 to 8 in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module otp_image_model (
  // Clock
  input wire logic clock,
  // OTP port
  input wire logic [3:0] otp_addr,
  input wire logic [8:0][31:0] image,
  output logic [31:0] otp_rdata,
  // Clock sources
  output logic reference_clock,
  output logic pll_clock_level
);
  logic [1:0] phase;
  int ref_count;

  // Data stands the cycle after the address; unmapped reads change pattern
  always @(posedge clock) begin
    otp_rdata <= (otp_addr <= 4'h8) ? image[otp_addr] : ~image[phase];
  end

  initial begin
    phase = 2'h0;
    ref_count = 0;
    reference_clock = 1'b0;
  end

  assign pll_clock_level = phase[1];

  always @(posedge clock) begin
    phase <= phase + 2'h1;
    // Half period of 700 cycles keeps the reference near 71 kHz
    if (ref_count == 699) begin
      ref_count <= 0;
      reference_clock <= ~reference_clock;
    end else begin
      ref_count <= ref_count + 1;
    end
  end
endmodule : otp_image_model
`default_nettype wire

//--- pll_config_mode_decode.sv
// Configuration store, mode pin decode and output control of the multiplier.
// Assumes OTP data arrives one cycle after otp_addr; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module pll_config_mode_decode
  import pll_config_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // OTP read port
  output logic [3:0] otp_addr,
  input wire logic [RATIO_W-1:0] otp_rdata,
  // Mode pins and reference clock
  input wire logic [1:0] mode_pins,
  input wire logic third_mode_pin,
  input wire logic reference_clock,
  // PLL side
  input wire logic pll_clock_level,
  input wire logic pll_locked,
  // Clock output pins
  output logic main_clock_out,
  output logic main_clock_oe,
  output logic aux_pin_out,
  output logic aux_pin_oe,
  // Synthesizer controls
  output ratio_out_type ratio_out,
  output logic auto_ratio_modifier_active,
  output logic missing_pulse_tolerance_enable,
  output logic [2:0] min_loop_bandwidth_code,
  output logic [7:0] min_loop_bandwidth_hz,
  output logic config_ready
);

  load_state_type state;
  logic read_pending;
  logic [3:0] read_index;
  logic [RATIO_W-1:0] ratio_words [SET_COUNT];
  modal_set_type modal_sets [SET_COUNT];
  global_set_type global_set;

  logic [SYNC_WIDTH-1:0] pins_sync;
  logic [1:0] mode_sync;
  logic third_pin_sync;
  logic ref_sync;
  logic locked_sync;
  logic aux_gated;
  logic aux_drive;

  level_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in({mode_pins, third_mode_pin, reference_clock, pll_locked}),
    .sync_out(pins_sync)
  );

  assign mode_sync = pins_sync[4:3];
  assign third_pin_sync = pins_sync[2];
  assign ref_sync = pins_sync[1];
  assign locked_sync = pins_sync[0];

  // OTP load sequencing
  wire load_last = (otp_addr == OTP_GLOBAL_ADDR);
  wire wr_ratio = read_pending && (read_index[3:2] == OTP_RATIO_BASE[3:2]);
  wire wr_modal = read_pending && (read_index[3:2] == OTP_MODAL_BASE[3:2]);
  wire wr_global = read_pending && (read_index == OTP_GLOBAL_ADDR);
  wire load_done = (state == ST_RUN) && !read_pending;

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      otp_addr <= OTP_RATIO_BASE;
      read_pending <= 1'b0;
      read_index <= OTP_RATIO_BASE;
    end else begin
      read_pending <= (state == ST_LOAD);
      read_index <= otp_addr;
      unique case (state)
        ST_IDLE: begin
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          if (load_last) begin
            state <= ST_RUN;
          end else begin
            otp_addr <= otp_addr + 4'h1;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Modal sets per mode, global set once; written only during the load
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < SET_COUNT; i++) begin
        ratio_words[i] <= RATIO_RESET;
        modal_sets[i] <= MODAL_RESET;
      end
      global_set <= GLOBAL_RESET;
    end else begin
      if (wr_ratio) begin
        ratio_words[read_index[1:0]] <= otp_rdata;
      end
      if (wr_modal) begin
        modal_sets[read_index[1:0]] <= modal_set_type'(otp_rdata[4:0]);
      end
      if (wr_global) begin
        global_set <= global_set_type'(otp_rdata[9:0]);
      end
    end
  end

  // Active set and third pin decode
  wire modal_set_type modal = modal_sets[mode_sync];
  wire [RATIO_W-1:0] ratio_sel = ratio_words[mode_sync];
  wire [2:0] pin_fn = global_set.third_mode_pin_function;
  wire fn_main_off = (pin_fn == FN_DIS_MAIN) || (pin_fn == FN_DIS_BOTH);
  wire fn_aux_off = (pin_fn == FN_DIS_AUX) || (pin_fn == FN_DIS_BOTH);
  wire dis_main = third_pin_sync && fn_main_off;
  wire dis_aux = third_pin_sync && fn_aux_off;
  wire shift_en = third_pin_sync && (pin_fn == FN_SHIFT_GATE);
  wire auto_ovr = (pin_fn == FN_AUTO_OVR);
  wire auto_en = auto_ovr ? third_pin_sync : modal.auto_ratio_modifier_enable;
  wire force_pll = third_pin_sync && (pin_fn == FN_FORCE_PLL);
  wire [1:0] aux_src = force_pll ? AUX_SRC_PLL : modal.aux_pin_source_select;

  // Ratio shaping
  wire [2:0] shift_places = {1'b0, modal.ratio_shift_select} + SHIFT_BIAS;
  wire [RATIO_W-1:0] shifted = ratio_sel >> shift_places;
  wire [RATIO_W-1:0] modified = shift_en ? shifted : ratio_sel;
  wire fmt = global_set.ratio_fixed_point_format;
  wire [INT_W-1:0] int_hi = {8'h00, ratio_sel[RATIO_W-1:FRAC_12_20]};
  wire [INT_W-1:0] int_lo = ratio_sel[RATIO_W-1:FRAC_20_12];
  wire [INT_W-1:0] ratio_int = fmt ? int_hi : int_lo;
  wire [7:0] bw_hz = BW_BASE_HZ << global_set.min_loop_bandwidth_code;

  // Output gating
  wire clock_run = locked_sync || global_set.outputs_live_while_unlocked;
  wire aux_is_clock = (aux_src == AUX_SRC_REF) || (aux_src == AUX_SRC_PLL);
  wire aux_level = (aux_src == AUX_SRC_REF) ? ref_sync : pll_clock_level;
  wire lock_mode = (aux_src == AUX_SRC_LOCK);
  wire open_drain = global_set.lock_indicator_drive_config;
  wire lock_level = !open_drain && !locked_sync;
  wire lock_oe = load_done && !dis_aux && (!open_drain || !locked_sync);

  clock_gate u_main_gate (
    .clock(clock),
    .srst(srst),
    .clock_level(pll_clock_level),
    .run(load_done && clock_run),
    .drive(load_done && !dis_main),
    .gated(main_clock_out),
    .drive_out(main_clock_oe)
  );

  clock_gate u_aux_gate (
    .clock(clock),
    .srst(srst),
    .clock_level(aux_level),
    .run(load_done && clock_run && aux_is_clock),
    .drive(load_done && !dis_aux),
    .gated(aux_gated),
    .drive_out(aux_drive)
  );

  // Registered pin and control outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      aux_pin_out <= 1'b0;
      aux_pin_oe <= 1'b0;
    end else begin
      aux_pin_out <= lock_mode ? lock_level : aux_gated;
      aux_pin_oe <= lock_mode ? lock_oe : aux_drive;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ratio_out <= '0;
      auto_ratio_modifier_active <= 1'b0;
      missing_pulse_tolerance_enable <= 1'b0;
      min_loop_bandwidth_code <= 3'h0;
      min_loop_bandwidth_hz <= BW_BASE_HZ;
      config_ready <= 1'b0;
    end else begin
      ratio_out <= '{ratio_sel, ratio_int, fmt, shift_en, shift_places, modified};
      auto_ratio_modifier_active <= load_done && auto_en;
      missing_pulse_tolerance_enable <= global_set.missing_pulse_tolerance_enable;
      min_loop_bandwidth_code <= global_set.min_loop_bandwidth_code;
      min_loop_bandwidth_hz <= bw_hz;
      config_ready <= load_done;
    end
  end

  // Checks
  a_ready_after_load: assert property (
    @(posedge clock) disable iff (srst)
    $fell(srst) |-> !config_ready ##[8:14] config_ready)
    else $error("Configuration not ready after OTP load");

  a_set_selection: assert property (
    @(posedge clock) disable iff (srst)
    config_ready ##1 $stable(mode_sync) |=>
      ratio_out.ratio_word == ratio_words[$past(mode_sync, 2)])
    else $error("Ratio word not taken from the selected set");

  a_shift_amount: assert property (
    @(posedge clock) disable iff (srst)
    shift_en |=> ratio_out.modified_ratio
      == ($past(ratio_sel) >> ({1'b0, $past(modal.ratio_shift_select)} + 3'h1)))
    else $error("Ratio shift by wrong number of places");

  a_shift_gated: assert property (
    @(posedge clock) disable iff (srst)
    !(third_pin_sync && pin_fn == FN_SHIFT_GATE) |=>
      !ratio_out.shift_enable && ratio_out.modified_ratio == ratio_out.ratio_word)
    else $error("Ratio shifted without pin and function 011");

  a_lock_push_pull: assert property (
    @(posedge clock) disable iff (srst)
    lock_mode && !open_drain && load_done && !dis_aux |=>
      aux_pin_oe && aux_pin_out == !$past(locked_sync))
    else $error("Push-pull unlock indicator wrong");

  a_lock_open_drain: assert property (
    @(posedge clock) disable iff (srst)
    lock_mode && open_drain |=> !aux_pin_out && (aux_pin_oe -> !$past(locked_sync)))
    else $error("Open-drain unlock indicator wrong");

  a_unlock_low: assert property (
    @(posedge clock) disable iff (srst)
    (!clock_run && !pll_clock_level) ##1 !clock_run |=> !main_clock_out)
    else $error("Main clock toggles while unlocked");

  a_no_runt_main: assert property (
    @(posedge clock) disable iff (srst)
    (main_clock_out != $past(main_clock_out)) |-> main_clock_out == $past(pll_clock_level))
    else $error("Partial clock period on main output");

  a_main_disable: assert property (
    @(posedge clock) disable iff (srst)
    (dis_main && !pll_clock_level) ##1 dis_main |=> !main_clock_oe)
    else $error("Main output driven while disabled");

  a_auto_override: assert property (
    @(posedge clock) disable iff (srst)
    load_done && auto_ovr |=> auto_ratio_modifier_active == $past(third_pin_sync))
    else $error("Auto modifier does not follow pin under 101");

  a_force_pll_src: assert property (
    @(posedge clock) disable iff (srst)
    force_pll |=> aux_pin_out == $past(aux_gated))
    else $error("Forced aux source is not the PLL clock path");

  a_format_int: assert property (
    @(posedge clock) disable iff (srst)
    fmt |=> ratio_out.ratio_integer[INT_W-1:12] == 8'h00)
    else $error("12.20 integer part too wide");

  a_bandwidth_hz: assert property (
    @(posedge clock) disable iff (srst)
    1'b1 |=> min_loop_bandwidth_hz == (8'h01 << $past(global_set.min_loop_bandwidth_code)))
    else $error("Loop bandwidth not doubling per code step");

  a_skip_follows: assert property (
    @(posedge clock) disable iff (srst)
    config_ready |-> missing_pulse_tolerance_enable == global_set.missing_pulse_tolerance_enable)
    else $error("Skip enable does not follow configuration");

  a_dis_aux_drive: assert property (
    @(posedge clock) disable iff (srst)
    (dis_aux && !aux_level) ##1 (dis_aux && !lock_mode) |=> !aux_pin_oe)
    else $error("Aux clock output driven while disabled");

  a_lock_disable: assert property (
    @(posedge clock) disable iff (srst)
    lock_mode && dis_aux |=> !aux_pin_oe)
    else $error("Lock indicator driven while disabled");

  a_load_order: assert property (
    @(posedge clock) disable iff (srst)
    state == ST_LOAD && !load_last |=> otp_addr == $past(otp_addr) + 4'h1)
    else $error("OTP address not ascending by one");

  a_addr_held: assert property (
    @(posedge clock) disable iff (srst)
    state == ST_RUN |-> otp_addr == OTP_GLOBAL_ADDR)
    else $error("OTP address moved after load");

  a_store_frozen: assert property (
    @(posedge clock) disable iff (srst)
    load_done |=> $stable(global_set))
    else $error("Global set changed after load");

  a_places_range: assert property (
    @(posedge clock) disable iff (srst)
    1'b1 |=> ratio_out.shift_places >= 3'h1 && ratio_out.shift_places <= 3'h4)
    else $error("Shift places outside one to four");

  a_format_lo: assert property (
    @(posedge clock) disable iff (srst)
    !fmt |=> ratio_out.ratio_integer == $past(ratio_sel[RATIO_W-1:FRAC_20_12]))
    else $error("20.12 integer part wrong");

  a_format_hi: assert property (
    @(posedge clock) disable iff (srst)
    fmt |=> ratio_out.ratio_integer[11:0] == $past(ratio_sel[RATIO_W-1:FRAC_12_20]))
    else $error("12.20 integer part wrong");

  a_unlock_aux: assert property (
    @(posedge clock) disable iff (srst)
    (!clock_run && !aux_level) ##1 (!clock_run && !lock_mode) |=> !aux_pin_out)
    else $error("Aux clock toggles while unlocked");

  a_main_enable: assert property (
    @(posedge clock) disable iff (srst)
    (load_done && !dis_main && !pll_clock_level) ##1 !dis_main |=> main_clock_oe)
    else $error("Main output not driven while enabled");

  a_auto_modal: assert property (
    @(posedge clock) disable iff (srst)
    load_done && !auto_ovr |=> auto_ratio_modifier_active == $past(modal.auto_ratio_modifier_enable))
    else $error("Auto modifier does not follow modal bit");

  a_quiet_before_ready: assert property (
    @(posedge clock) disable iff (srst)
    !config_ready |-> !main_clock_oe && !aux_pin_oe && !main_clock_out)
    else $error("Outputs active before configuration load");

  a_bw_code: assert property (
    @(posedge clock) disable iff (srst)
    1'b1 |=> min_loop_bandwidth_code == $past(global_set.min_loop_bandwidth_code))
    else $error("Loop bandwidth code not from global set");

endmodule : pll_config_mode_decode
`default_nettype wire

//--- pll_config_pkg.sv
// Constants, types and OTP layout for the clock multiplier configuration block.
// Assumes one 100 MHz synthesizer-domain clock and a synchronous OTP read port.
// Functional notes
// - Modal sets per mode, global set once
// - Four modal sets chosen by two mode pins
// - Shift select divides ratio by 2 to 16
// - Shift only with pin high, function 011
// - Aux source: reference, PLL clock, lock
// - Lock drive config used only for source 11
// - Config 0 push-pull high; 1 open-drain low
// - Auto modifier enable bit turns it on
// - Four 32-bit ratio words indexed by set
// - Skip enable keeps lock despite missing pulses
// - Clock outputs low while unlocked unless live bit
// - Format bit picks 20.12 or 12.20
// - Functions 000-010 make pin an output disable
// - 011 gates shift, 101 overrides auto modifier
// - 111 lets pin force aux to PLL clock
// - Bandwidth code doubles from 1 to 128 Hz
// - Disable pin low enables, high disables
// - Override pin high enables or forces source
// - Gating and enabling never produce runt clocks
package pll_config_pkg;

  localparam int RATIO_W = 32;
  localparam int SET_COUNT = 4;
  localparam int SYNC_WIDTH = 5;
  localparam int INT_W = 20;

  // OTP word addresses
  localparam logic [3:0] OTP_RATIO_BASE = 4'h0;
  localparam logic [3:0] OTP_MODAL_BASE = 4'h4;
  localparam logic [3:0] OTP_GLOBAL_ADDR = 4'h8;

  // Auxiliary source codes
  localparam logic [1:0] AUX_SRC_RESERVED = 2'h0;
  localparam logic [1:0] AUX_SRC_REF = 2'h1;
  localparam logic [1:0] AUX_SRC_PLL = 2'h2;
  localparam logic [1:0] AUX_SRC_LOCK = 2'h3;

  // Third mode pin function codes
  localparam logic [2:0] FN_DIS_MAIN = 3'h0;
  localparam logic [2:0] FN_DIS_AUX = 3'h1;
  localparam logic [2:0] FN_DIS_BOTH = 3'h2;
  localparam logic [2:0] FN_SHIFT_GATE = 3'h3;
  localparam logic [2:0] FN_AUTO_OVR = 3'h5;
  localparam logic [2:0] FN_FORCE_PLL = 3'h7;

  // Integer field positions of the two ratio formats
  localparam int FRAC_20_12 = 12;
  localparam int FRAC_12_20 = 20;

  localparam logic [7:0] BW_BASE_HZ = 8'h01;
  localparam logic [2:0] SHIFT_BIAS = 3'h1;

  typedef struct packed {
    logic [1:0] ratio_shift_select;
    logic [1:0] aux_pin_source_select;
    logic auto_ratio_modifier_enable;
  } modal_set_type;

  typedef struct packed {
    logic missing_pulse_tolerance_enable;
    logic lock_indicator_drive_config;
    logic outputs_live_while_unlocked;
    logic ratio_fixed_point_format;
    logic [2:0] third_mode_pin_function;
    logic [2:0] min_loop_bandwidth_code;
  } global_set_type;

  typedef struct packed {
    logic [RATIO_W-1:0] ratio_word;
    logic [INT_W-1:0] ratio_integer;
    logic ratio_fixed_point_format;
    logic shift_enable;
    logic [2:0] shift_places;
    logic [RATIO_W-1:0] modified_ratio;
  } ratio_out_type;

  localparam modal_set_type MODAL_RESET = '0;
  localparam global_set_type GLOBAL_RESET = '0;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } load_state_type;

endpackage : pll_config_pkg

//--- tb.sv
// Self-checking bench for the mode decode block: OTP load, pin functions, outputs.
// Assumes the OTP image model as far side and pins driven from this bench.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pll_config_pkg::*;
  logic clock, srst, third_mode_pin, pll_locked, reference_clock, pll_clock_level;
  logic [1:0] mode_pins;
  logic [3:0] otp_addr;
  logic [31:0] otp_rdata;
  logic [8:0][31:0] image;
  logic main_clock_out, main_clock_oe, aux_pin_out, aux_pin_oe, config_ready;
  logic auto_ratio_modifier_active, missing_pulse_tolerance_enable;
  logic [2:0] min_loop_bandwidth_code;
  logic [7:0] min_loop_bandwidth_hz;
  ratio_out_type ratio_out;
  logic [9:0] glob;
  int failures, samples_checked, main_rises, aux_rises;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  otp_image_model partner (.clock(clock), .otp_addr(otp_addr), .image(image),
    .otp_rdata(otp_rdata), .reference_clock(reference_clock),
    .pll_clock_level(pll_clock_level));

  pll_config_mode_decode DUT (.clock(clock), .srst(srst), .otp_addr(otp_addr),
    .otp_rdata(otp_rdata), .mode_pins(mode_pins), .third_mode_pin(third_mode_pin),
    .reference_clock(reference_clock), .pll_clock_level(pll_clock_level),
    .pll_locked(pll_locked), .main_clock_out(main_clock_out), .main_clock_oe(main_clock_oe),
    .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe), .ratio_out(ratio_out),
    .auto_ratio_modifier_active(auto_ratio_modifier_active),
    .missing_pulse_tolerance_enable(missing_pulse_tolerance_enable),
    .min_loop_bandwidth_code(min_loop_bandwidth_code),
    .min_loop_bandwidth_hz(min_loop_bandwidth_hz), .config_ready(config_ready));

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0b seen %0b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Counts rising edges of both clock pins over a window
  task automatic watch(input int cycles);
    logic pm, pa;
    main_rises = 0;
    aux_rises = 0;
    pm = main_clock_out;
    pa = aux_pin_out;
    repeat (cycles) begin
      @(posedge clock);
      #1;
      if (main_clock_out === 1'b1 && pm === 1'b0) main_rises++;
      if (aux_pin_out === 1'b1 && pa === 1'b0) aux_rises++;
      pm = main_clock_out;
      pa = aux_pin_out;
    end
  endtask : watch

  // Resets, lets the OTP load run and waits for the ready flag
  task automatic load_config(input logic [9:0] g);
    int n;
    @(posedge clock);
    image[8] <= {22'h0, g};
    srst <= 1'b1;
    @(posedge clock);
    #1;
    check_bit("ready in reset", 1'b0, config_ready);
    check_bit("main oe in reset", 1'b0, main_clock_oe);
    check_word("otp address in reset", 32'h0, {28'h0, otp_addr});
    check_word("bandwidth in reset", 32'h1, {24'h0, min_loop_bandwidth_hz});
    @(posedge clock);
    srst <= 1'b0;
    n = 0;
    while (config_ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check_bit("config ready", 1'b1, config_ready);
    if (n >= 20) tally_and_finish();
  endtask : load_config

  task automatic apply_and_check(input logic [9:0] g, input int set, input logic pin,
                                 input logic lk);
    logic [4:0] modal;
    logic [31:0] word;
    logic [2:0] fn, places;
    logic [1:0] src;
    logic shen, mdis, adis, live, cfg;
    fn = g[5:3];
    live = g[7];
    cfg = g[8];
    modal = image[4 + set][4:0];
    word = image[set];
    places = {1'b0, modal[4:3]} + 3'h1;
    shen = (fn == FN_SHIFT_GATE) && pin;
    mdis = pin && (fn == FN_DIS_MAIN || fn == FN_DIS_BOTH);
    adis = pin && (fn == FN_DIS_AUX || fn == FN_DIS_BOTH);
    src = (fn == FN_FORCE_PLL && pin) ? AUX_SRC_PLL : modal[2:1];
    @(posedge clock);
    mode_pins <= set[1:0];
    third_mode_pin <= pin;
    pll_locked <= lk;
    repeat (12) @(posedge clock);
    #1;
    check_word("otp address held", 32'h8, {28'h0, otp_addr});
    check_word("ratio word", word, ratio_out.ratio_word);
    check_word("ratio integer", g[6] ? {20'h0, word[31:20]} : {12'h0, word[31:12]},
               {12'h0, ratio_out.ratio_integer});
    check_bit("format", g[6], ratio_out.ratio_fixed_point_format);
    check_bit("shift enable", shen, ratio_out.shift_enable);
    check_word("shift places", {29'h0, places}, {29'h0, ratio_out.shift_places});
    check_word("modified ratio", shen ? word >> places : word, ratio_out.modified_ratio);
    check_bit("auto modifier", fn == FN_AUTO_OVR ? pin : modal[0],
              auto_ratio_modifier_active);
    check_word("bandwidth hz", 32'h1 << g[2:0], {24'h0, min_loop_bandwidth_hz});
    check_word("bandwidth code", {29'h0, g[2:0]}, {29'h0, min_loop_bandwidth_code});
    check_bit("skip enable", g[9], missing_pulse_tolerance_enable);
    watch((src == AUX_SRC_REF) ? 1500 : 16);
    check_bit("main oe", !mdis, main_clock_oe);
    check_bit("main clock runs", lk || live, main_rises > 0);
    if (!lk && !live) begin
      check_bit("main held low", 1'b1, main_rises == 0 && main_clock_out === 1'b0);
    end
    if (src == AUX_SRC_LOCK) begin
      if (!adis) check_bit("aux lock level", cfg ? 1'b0 : !lk, aux_pin_out);
      check_bit("aux lock drive", !adis && (!cfg || !lk), aux_pin_oe);
    end else begin
      check_bit("aux oe", !adis, aux_pin_oe);
      if (src == AUX_SRC_PLL && !adis && (lk || !live))
        check_bit("aux pll clock", lk, aux_rises > 0);
      if (src == AUX_SRC_REF && lk && !adis)
        check_bit("aux reference", 1'b1, aux_rises > 0);
      if (src == AUX_SRC_RESERVED) check_bit("aux reserved", 1'b0, aux_pin_out);
    end
  endtask : apply_and_check

  initial begin
    failures = 0;
    samples_checked = 0;
    srst = 1'b1;
    mode_pins = 2'h0;
    third_mode_pin = 1'b0;
    pll_locked = 1'b0;
    image = '0;
    image[0] = 32'h0013_A92A;
    image[1] = 32'h1000_0000;
    image[2] = 32'h3200_0000;
    image[3] = 32'h2DF5_E208;
    // Modal words: shift select, aux source, auto enable
    image[4] = 32'h0000_0003;
    image[5] = 32'h0000_000C;
    image[6] = 32'h0000_0017;
    image[7] = 32'h0000_0018;
    // Each pass sets one pin function and one bandwidth code
    for (int i = 0; i < 8; i++) begin
      glob = {i[1], i[0] ^ i[1], i[2], i[0], 3'(i), 3'(7 - i)};
      load_config(glob);
      for (int s = 0; s < 4; s++) begin
        for (int p = 0; p < 2; p++) begin
          for (int l = 1; l >= 0; l--) begin
            apply_and_check(glob, s, p[0], l[0]);
          end
        end
      end
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
